// [bench/smp_master_props.sv]
// Property checker for the serial master port
`timescale 1ns/1ps
module smp_master_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic portEnable,
  input wire logic [4:0] frameBitsM1,
  input wire logic clkPolarity,
  input wire logic [7:0] prescaleDiv,
  input wire logic [7:0] bitRateDiv,
  input wire logic [3:0] burstLen,
  input wire logic [2:0] intMask,
  input wire logic txWrValid,
  input wire logic txWrReady,
  input wire logic rxRdValid,
  input wire logic rxRdReady,
  input wire logic [5:0] txLevel,
  input wire logic [5:0] rxLevel,
  input wire logic txBurstReq,
  input wire logic [2:0] intRaw,
  input wire logic intOut,
  input wire logic busy,
  input wire logic serialOutputClock,
  input wire logic frameSelect_n
);
  logic sckQ;
  logic seen;
  logic [15:0] gap;
  logic [6:0] togs;
  logic [15:0] hExp;
  logic [6:0] nExp;
  logic [6:0] bl;
  logic tog;
  assign tog = sckQ != serialOutputClock;
  assign hExp = (prescaleDiv[7:1] == 7'h00 ? 16'h0001 : {9'h000, prescaleDiv[7:1]}) * ({8'h00, bitRateDiv} + 16'h0001);
  assign nExp = frameBitsM1 < 5'h03 ? 7'h04 : {2'h0, frameBitsM1} + 7'h01;
  assign bl = burstLen == 4'h0 ? 7'h01 : (burstLen > 4'h8 ? 7'h08 : {3'h0, burstLen});
  // Counts restart each frame, so idle level changes never count as edges
  always_ff @(posedge sys_clk) begin
    sckQ <= serialOutputClock;
    if (!rst_n || frameSelect_n) begin
      seen <= 1'b0;
      gap <= 16'h0000;
      togs <= 7'h00;
    end else begin
      seen <= seen | tog;
      gap <= tog ? 16'h0000 : gap + 16'h0001;
      togs <= togs + {6'h00, tog};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_idle_clock: assert property ($past(rst_n) && frameSelect_n && $stable(clkPolarity) |-> serialOutputClock == clkPolarity)
    else $error("clock off idle level");
  a_half_period: assert property (tog && seen |-> gap == hExp - 16'h0001)
    else $error("half period wrong");
  a_edge_count: assert property ($rose(frameSelect_n) |-> togs == {nExp[5:0], 1'b0})
    else $error("edge count wrong");
  a_tx_full: assert property (txLevel == 6'h20 |-> !txWrReady)
    else $error("write ready while full");
  a_tx_push: assert property (txWrValid && txWrReady && !portEnable |=> txLevel == $past(txLevel) + 6'h01)
    else $error("write not stored");
  a_rx_pop: assert property (rxRdValid && rxRdReady && frameSelect_n && !busy |=> rxLevel == $past(rxLevel) - 6'h01)
    else $error("read not popped");
  a_tx_burst: assert property ($past(rst_n) && $stable(txLevel) && $stable(burstLen)
    |-> txBurstReq == (7'h20 - {1'b0, txLevel} >= bl))
    else $error("burst request wrong");
  a_int_comb: assert property ($past(rst_n) && $stable(intRaw) && $stable(intMask) |-> intOut == |(intRaw & intMask))
    else $error("interrupt wrong");
  a_select_busy: assert property (!frameSelect_n |-> busy)
    else $error("select without frame");
  c_full: cover property (txLevel == 6'h20);
  c_overrun: cover property ($rose(intRaw[2]));
  c_frame: cover property ($rose(frameSelect_n));
endmodule : smp_master_props
bind smp_master smp_master_props chk (.*);

// [bench/smp_slave.sv]
// Behavioural serial slave facing the master port
`timescale 1ns/1ps
module smp_slave (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdo,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [5:0] nBits,
  input wire logic [31:0] txWord,
  output logic sdi,
  output logic [31:0] rxWord
);
  int idx = 0;
  initial sdi = 1'b0;
  initial rxWord = 32'h0000_0000;
  always @(negedge sel_n) begin
    rxWord = 32'h0000_0000;
    idx = int'(nBits);
    if (!cpha) begin // Phase 0 shows the first bit before any edge
      idx--;
      sdi = txWord[idx];
    end
  end
  // A released line shows the inverse, so a late sample never sees the old bit
  always @(posedge sel_n) sdi = ~sdi;
  always @(sclk) begin
    if (!sel_n && ((sclk ^ cpol) != cpha)) begin
      rxWord = {rxWord[30:0], sdo};
    end else if (!sel_n && idx > 0) begin
      idx--;
      sdi = txWord[idx];
    end
  end
endmodule : smp_slave

// [bench/tb_top.sv]
// Self-checking bench for the serial master port
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic portEnable = 1'b0;
  logic [4:0] frameBitsM1 = 5'h00;
  logic clkPolarity = 1'b0;
  logic clkPhase = 1'b0;
  logic [7:0] prescaleDiv = 8'h00;
  logic [7:0] bitRateDiv = 8'h00;
  logic [3:0] burstLen = 4'h8;
  logic [2:0] intMask = 3'h4;
  logic overrunClear = 1'b0;
  logic [31:0] txWrData = 32'h0000_0000;
  logic txWrValid = 1'b0;
  logic rxRdReady = 1'b0;
  logic [31:0] slaveWord = 32'h0000_000C;
  logic [5:0] nBits = 6'h04;
  logic [31:0] rxRdData, slaveRx;
  logic txWrReady, rxRdValid, txBurstReq, rxBurstReq, intOut, busy;
  logic serialOutputClock, serialDataOut, frameSelect_n, serialDataInPin;
  logic [5:0] txLevel, rxLevel;
  logic [2:0] intRaw;
  int numErrors = 0;
  int totalChecks = 0;
  logic [4:0] fb [4] = '{5'h1F, 5'h02, 5'h07, 5'h0C};
  smp_master dut (.*);
  smp_slave peer (.sclk(serialOutputClock), .sel_n(frameSelect_n), .sdo(serialDataOut), .cpol(clkPolarity),
    .cpha(clkPhase), .nBits(nBits), .txWord(slaveWord), .sdi(serialDataInPin), .rxWord(slaveRx));
  always #10 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic giveVerdict;
    if (numErrors == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : giveVerdict
  // Gives up quietly after a while, which is how a refused write is made
  task automatic wr(input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    txWrValid <= 1'b1;
    txWrData <= d;
    @(negedge sys_clk);
    while (txWrReady !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    txWrValid <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] e);
    int n = 0;
    @(negedge sys_clk);
    while (rxRdValid !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check("rxRdData", rxRdData, e);
    @(posedge sys_clk);
    rxRdReady <= 1'b1;
    @(posedge sys_clk);
    rxRdReady <= 1'b0;
  endtask : rd
  task automatic drain;
    int n = 0;
    @(negedge sys_clk);
    while ((busy !== 1'b0 || frameSelect_n !== 1'b1 || txLevel !== 6'h00) && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    // Wait eight more cycles after the last frame has ended
    repeat (8) @(negedge sys_clk);
  endtask : drain
  initial begin
    repeat (40000) @(posedge sys_clk);
    numErrors++;
    giveVerdict;
  end
  initial begin
    int nb;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check("frameSelect_n", frameSelect_n, 32'h1);
    check("rxRdValid", rxRdValid, 32'h0);
    for (int i = 0; i < 32; i++) wr(32'hA5A5_A5A0 | i);
    @(negedge sys_clk);
    check("txLevel", txLevel, 32'h20);
    wr(32'h0000_0003);
    @(negedge sys_clk);
    check("txLevel", txLevel, 32'h20);
    check("txBurstReq", txBurstReq, 32'h0);
    @(posedge sys_clk);
    portEnable <= 1'b1;
    wr(32'h0000_0007);
    drain;
    check("rxLevel", rxLevel, 32'h20);
    check("rxBurstReq", rxBurstReq, 32'h1);
    check("overrun", intRaw[2], 32'h1);
    check("intOut", intOut, 32'h1);
    check("slaveRx", slaveRx, 32'h7);
    @(posedge sys_clk);
    overrunClear <= 1'b1;
    @(posedge sys_clk);
    overrunClear <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check("intOut", intOut, 32'h0);
    repeat (32) rd(32'h0000_000C);
    @(negedge sys_clk);
    check("rxRdValid", rxRdValid, 32'h0);
    check("rxBurstReq", rxBurstReq, 32'h0);
    for (int m = 0; m < 4; m++) begin
      nb = fb[m] < 5'h03 ? 4 : int'(fb[m]) + 1;
      @(posedge sys_clk);
      portEnable <= 1'b0;
      {clkPolarity, clkPhase} <= 2'(m);
      frameBitsM1 <= fb[m];
      prescaleDiv <= 8'(2 * m);
      bitRateDiv <= 8'(3 - m);
      burstLen <= 4'(5 * m);
      intMask <= 3'(m + 1);
      nBits <= 6'(nb);
      slaveWord <= 32'h96E1_3C5A ^ m;
      wr(32'hC3A5_5A3C + m);
      @(posedge sys_clk);
      portEnable <= 1'b1;
      drain;
      check("slaveRx", slaveRx, (32'hC3A5_5A3C + m) & (32'hFFFF_FFFF >> (32 - nb)));
      rd((32'h96E1_3C5A ^ m) & (32'hFFFF_FFFF >> (32 - nb)));
    end
    giveVerdict;
  end
endmodule : tb_top

// [include/smp_consts.svh]
// Constants for the synchronous serial master port
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH
`define SMP_WORD_W 32
`define SMP_FIFO_DEPTH 32
`define SMP_PTR_W 5
`define SMP_LVL_W 6
`define SMP_FRAME_MIN_M1 5'h03
`define SMP_BURST_MAX 4'h8
`define SMP_WATER 6'h10
`define SMP_INT_TXLOW 0
`define SMP_INT_RXHIGH 1
`define SMP_INT_OVERRUN 2
`define SMP_INT_W 3
`endif

// [include/smp_pkg.sv]
// Types shared by the synchronous serial master port
package smp_pkg;
  typedef enum logic [1:0] {
    SMP_IDLE,
    SMP_SHIFT,
    SMP_STORE,
    SMP_GAP
  } smp_state_e;
endpackage : smp_pkg

// [src/smp_fifo.sv]
// Show-ahead word buffer with registered flags and head word
`timescale 1ns/1ps
`include "smp_consts.svh"
module smp_fifo (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`SMP_WORD_W-1:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [`SMP_WORD_W-1:0] rdData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [`SMP_LVL_W-1:0] level
);
  logic [`SMP_WORD_W-1:0] memArr [0:`SMP_FIFO_DEPTH-1];
  logic [`SMP_PTR_W-1:0] wrPtr_reg;
  logic [`SMP_PTR_W-1:0] rdPtr_reg;
  logic [`SMP_PTR_W-1:0] rdPtr_next;
  logic [`SMP_LVL_W-1:0] count_reg;
  logic [`SMP_LVL_W-1:0] count_next;
  logic [`SMP_LVL_W-1:0] kept;
  logic [`SMP_WORD_W-1:0] head_next;
  logic doWr;
  logic doRd;

  assign doWr = wrValid & wrReady;
  assign doRd = rdReady & rdValid;

  always_comb begin
    rdPtr_next = doRd ? rdPtr_reg + 5'h01 : rdPtr_reg;
    kept = doRd ? count_reg - 6'h01 : count_reg;
    count_next = doWr ? kept + 6'h01 : kept;
    // An empty buffer passes the incoming word straight to the head
    if (kept == 6'h00) begin
      head_next = doWr ? wrData : 32'h0000_0000;
    end else begin
      head_next = memArr[rdPtr_next];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn && doWr) begin
      memArr[wrPtr_reg] <= wrData; // [RULE_06]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_reg <= 5'h00;
      rdPtr_reg <= 5'h00;
      count_reg <= 6'h00;
      wrReady <= 1'b1;
      rdValid <= 1'b0;
      rdData <= 32'h0000_0000;
    end else if (clkEn) begin
      if (doWr) begin
        wrPtr_reg <= wrPtr_reg + 5'h01;
      end
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      wrReady <= count_next != 6'h20; // [RULE_04]
      rdValid <= count_next != 6'h00;
      rdData <= head_next;
    end
  end

  assign level = count_reg;
endmodule : smp_fifo

// [src/smp_master.sv]
// Synchronous serial master port: word buffers, clock generation and shift engine
`timescale 1ns/1ps
`include "smp_consts.svh"
// How it works
// [RULE_01] The port is always the master, making the serial clock and starting every frame itself.
// [RULE_02] Bits from the serial input are collected into a word that is pushed into the receive buffer.
// [RULE_03] Words from the transmit buffer are sent bit by bit, most significant first, on the serial output.
// [RULE_04] Transmit and receive each have their own buffer of 32 words of 32 bits.
// [RULE_05] Burst request flags tell the processor or DMA when a burst of one to eight words can move.
// [RULE_06] One 32-bit word on the system side always takes exactly one buffer entry.
// [RULE_07] The serial clock comes from the system clock through a prescaler and then a rate divider.
// [RULE_08] One interrupt output is high while any unmasked internal event is active.
// [RULE_09] Frame length is programmable from 4 to 32 bits.
// [RULE_10] Clock idle level and sampling phase are selectable and the slave must use the same setting.
// [RULE_11] Short frames use the low bits of a transmit word and return right-justified words with zeros above.
// [RULE_12] With the transmit buffer empty and no frame running, the clock stops at its idle level.
module smp_master
  import smp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic portEnable,
  input wire logic [4:0] frameBitsM1,
  input wire logic clkPolarity,
  input wire logic clkPhase,
  input wire logic [7:0] prescaleDiv,
  input wire logic [7:0] bitRateDiv,
  input wire logic [3:0] burstLen,
  input wire logic [`SMP_INT_W-1:0] intMask,
  input wire logic overrunClear,
  input wire logic [`SMP_WORD_W-1:0] txWrData,
  input wire logic txWrValid,
  output logic txWrReady,
  output logic [`SMP_WORD_W-1:0] rxRdData,
  output logic rxRdValid,
  input wire logic rxRdReady,
  output logic [`SMP_LVL_W-1:0] txLevel,
  output logic [`SMP_LVL_W-1:0] rxLevel,
  output logic txBurstReq,
  output logic rxBurstReq,
  output logic [`SMP_INT_W-1:0] intRaw,
  output logic intOut,
  output logic busy,
  output logic serialOutputClock,
  output logic serialDataOut,
  output logic frameSelect_n,
  input wire logic serialDataInPin
);
  smp_state_e state_reg;
  logic [`SMP_WORD_W-1:0] txHead;
  logic txHeadValid;
  logic txPop;
  logic rxPush;
  logic rxSpace;
  logic [`SMP_WORD_W-1:0] txShift_reg;
  logic [`SMP_WORD_W-1:0] rxShift_reg;
  logic [4:0] bitsM1_reg;
  logic [5:0] edgeCnt_reg;
  logic [6:0] preCnt_reg;
  logic [7:0] rateCnt_reg;
  logic preTick;
  logic edgeTick;
  logic leadingEdge;
  logic lastEdge;
  logic overrun_reg;
  logic [`SMP_INT_W-1:0] events;
  logic [4:0] effBitsM1;
  logic [3:0] effBurst;
  logic [`SMP_WORD_W-1:0] startWord;

  // Frame lengths below the minimum are raised to it
  function automatic logic [4:0] clampBits(input logic [4:0] m1);
    clampBits = (m1 < `SMP_FRAME_MIN_M1) ? `SMP_FRAME_MIN_M1 : m1;
  endfunction : clampBits

  // Moves the frame's top bit to word bit 31 so shifting is always from the top
  function automatic logic [`SMP_WORD_W-1:0] alignTop(input logic [`SMP_WORD_W-1:0] w, input logic [4:0] m1);
    alignTop = w << (5'h1F - m1);
  endfunction : alignTop

  assign effBitsM1 = clampBits(frameBitsM1); // [RULE_09]
  assign effBurst = (burstLen == 4'h0) ? 4'h1 : ((burstLen > `SMP_BURST_MAX) ? `SMP_BURST_MAX : burstLen);
  assign startWord = alignTop(txHead, effBitsM1); // [RULE_11]

  smp_fifo txFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .wrData(txWrData),
    .wrValid(txWrValid),
    .wrReady(txWrReady),
    .rdData(txHead),
    .rdValid(txHeadValid),
    .rdReady(txPop),
    .level(txLevel)
  );

  smp_fifo rxFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .wrData(rxShift_reg),
    .wrValid(rxPush),
    .wrReady(rxSpace),
    .rdData(rxRdData),
    .rdValid(rxRdValid),
    .rdReady(rxRdReady),
    .level(rxLevel)
  );

  // A new frame only starts when a word is waiting, so the clock stays parked otherwise
  assign txPop = (state_reg == SMP_IDLE) && portEnable && txHeadValid; // [RULE_03] [RULE_12]
  assign rxPush = (state_reg == SMP_STORE); // [RULE_02]

  // Prescaler runs at half the programmed value since every tick is one clock half
  assign preTick = (preCnt_reg >= prescaleDiv[7:1]) || (prescaleDiv[7:1] == 7'h00) ||
                   (preCnt_reg == prescaleDiv[7:1] - 7'h01);
  assign edgeTick = preTick && (rateCnt_reg == bitRateDiv); // [RULE_07]
  assign leadingEdge = !edgeCnt_reg[0];
  assign lastEdge = (edgeCnt_reg == {bitsM1_reg, 1'b1});

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      preCnt_reg <= 7'h00;
      rateCnt_reg <= 8'h00;
    end else if (clkEn) begin
      // Dividers rest in idle and store so every frame and every gap starts on a full half period
      if (state_reg != SMP_SHIFT && state_reg != SMP_GAP) begin
        preCnt_reg <= 7'h00;
        rateCnt_reg <= 8'h00;
      end else if (preTick) begin
        preCnt_reg <= 7'h00;
        rateCnt_reg <= (rateCnt_reg >= bitRateDiv) ? 8'h00 : rateCnt_reg + 8'h01; // [RULE_07]
      end else begin
        preCnt_reg <= preCnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= SMP_IDLE;
      edgeCnt_reg <= 6'h00;
      bitsM1_reg <= 5'h1F;
    end else if (clkEn) begin
      case (state_reg)
        SMP_IDLE: begin
          edgeCnt_reg <= 6'h00;
          if (txPop) begin
            bitsM1_reg <= effBitsM1; // [RULE_09]
            state_reg <= SMP_SHIFT; // [RULE_01]
          end
        end
        SMP_SHIFT: begin
          if (edgeTick) begin
            edgeCnt_reg <= edgeCnt_reg + 6'h01;
            if (lastEdge) begin
              state_reg <= SMP_STORE;
            end
          end
        end
        SMP_STORE: begin
          state_reg <= SMP_GAP;
        end
        SMP_GAP: begin
          // Select stays released for one half period between frames
          if (edgeTick) begin
            state_reg <= SMP_IDLE;
          end
        end
        default: begin
          state_reg <= SMP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serialOutputClock <= 1'b0;
      frameSelect_n <= 1'b1;
    end else if (clkEn) begin
      if (state_reg == SMP_SHIFT) begin
        frameSelect_n <= 1'b0;
        if (edgeTick) begin
          serialOutputClock <= ~serialOutputClock; // [RULE_01]
        end
      end else begin
        serialOutputClock <= clkPolarity; // [RULE_10] [RULE_12]
        frameSelect_n <= !txPop;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txShift_reg <= 32'h0000_0000;
      serialDataOut <= 1'b0;
    end else if (clkEn) begin
      if (txPop) begin
        // Phase 0 must present the first bit before the first clock edge
        if (!clkPhase) begin
          serialDataOut <= startWord[31];
          txShift_reg <= startWord << 1;
        end else begin
          txShift_reg <= startWord;
        end
      end else if (state_reg == SMP_SHIFT && edgeTick && (leadingEdge == clkPhase) && !lastEdge) begin
        serialDataOut <= txShift_reg[31]; // [RULE_03] [RULE_10]
        txShift_reg <= txShift_reg << 1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxShift_reg <= 32'h0000_0000;
    end else if (clkEn) begin
      if (txPop) begin
        rxShift_reg <= 32'h0000_0000; // [RULE_11]
      end else if (state_reg == SMP_SHIFT && edgeTick && (leadingEdge != clkPhase)) begin
        rxShift_reg <= {rxShift_reg[30:0], serialDataInPin}; // [RULE_02] [RULE_10]
      end
    end
  end

  // A frame that finds the receive buffer full is dropped and flagged; a new one beats a clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (clkEn) begin
      if (rxPush && !rxSpace) begin
        overrun_reg <= 1'b1;
      end else if (overrunClear) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    events = '0;
    events[`SMP_INT_TXLOW] = txLevel <= `SMP_WATER;
    events[`SMP_INT_RXHIGH] = rxLevel >= `SMP_WATER;
    events[`SMP_INT_OVERRUN] = overrun_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      intRaw <= '0;
      intOut <= 1'b0;
      busy <= 1'b0;
    end else if (clkEn) begin
      intRaw <= events;
      intOut <= |(events & intMask); // [RULE_08]
      busy <= (state_reg != SMP_IDLE) || txPop;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txBurstReq <= 1'b0;
      rxBurstReq <= 1'b0;
    end else if (clkEn) begin
      txBurstReq <= ({2'b00, effBurst} + txLevel) <= 6'h20; // [RULE_05]
      rxBurstReq <= rxLevel >= {2'b00, effBurst}; // [RULE_05]
    end
  end
endmodule : smp_master
